// [pkg/pse_class_pkg.sv]
// Shared constants and carriers of the class and capacitance readback bank
package pse_class_pkg;

   // -------------------------------------------------------------
   // Command codes (register offsets), unmapped read value and spent byte
   // -------------------------------------------------------------
   localparam logic [7:0] OFF_CH4_CAP = 8'h4b;
   localparam logic [7:0] OFF_CH1_CLASS = 8'h4c;
   localparam logic [7:0] OFF_CH2_CLASS = 8'h4d;
   localparam logic [7:0] OFF_CH3_CLASS = 8'h4e;
   localparam logic [7:0] OFF_CH4_CLASS = 8'h4f;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam logic [7:0] SPENT_BYTE = 8'hff;

   // -------------------------------------------------------------
   // Reset values and field positions
   // -------------------------------------------------------------
   localparam logic [7:0] CAP_RESET = 8'h00;
   localparam logic [7:0] CLASS_RESET = 8'h00;
   localparam int GRANTED_MSB = 7;
   localparam int GRANTED_LSB = 4;
   localparam int PRIOR_MSB = 3;
   localparam int PRIOR_LSB = 0;

   // -------------------------------------------------------------
   // Class codes
   // -------------------------------------------------------------
   localparam logic [3:0] CLS_UNKNOWN = 4'h0;
   localparam logic [3:0] CLS_1 = 4'h1;
   localparam logic [3:0] CLS_3 = 4'h3;
   localparam logic [3:0] CLS_4 = 4'h4;
   localparam logic [3:0] CLS_0 = 4'h6;
   localparam logic [3:0] CLS_5_SS = 4'h8;
   localparam logic [3:0] CLS_8_SS = 4'hb;
   localparam logic [3:0] CLS_5_DS = 4'hd;

   // Per-channel class report from the discovery engine
   typedef struct packed {
      logic valid;
      logic [3:0] granted;
      logic [3:0] prior;
   } class_report_t;

   // Per-channel operating state
   typedef struct packed {
      logic off;
      logic semi_auto;
      logic detect_en;
      logic class_en;
   } chan_state_t;

endpackage : pse_class_pkg

// [design/i2c_byte_target.sv]
// Serial target that serves one-byte command reads and swallows writes
`timescale 1ns/1ns
module i2c_byte_target #(
   parameter logic [6:0] DEV_ADDR = 7'h20
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   output logic [7:0] cmd,
   output logic rd_req,
   input wire logic [7:0] rd_data
);

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_ADDR = 4'b0001,
      ST_ACK_ADDR = 4'b0010,
      ST_CMD = 4'b0011,
      ST_ACK_CMD = 4'b0100,
      ST_WDATA = 4'b0101,
      ST_ACK_W = 4'b0110,
      ST_RDATA = 4'b0111,
      ST_ACK_R = 4'b1000
   } tgt_state_t;

   tgt_state_t state, next_state;
   logic scl_q, sda_q, next_drive, drive, rw, next_rw, extra, next_extra;
   logic [3:0] cnt, next_cnt;
   logic [7:0] shift, next_shift, tx, next_tx, next_cmd;
   logic rise, fall, start_c, stop_c;

   // -------------------------------------------------------------
   // Line events
   // -------------------------------------------------------------
   assign rise = scl_in && !scl_q;
   assign fall = !scl_in && scl_q;
   assign start_c = scl_in && scl_q && sda_q && !sda_in;
   assign stop_c = scl_in && scl_q && !sda_q && sda_in;
   assign sda_out = 1'b0; // Open drain: only ever pulls low
   assign sda_oe_n = !drive;
   assign rd_req = fall && state == ST_ACK_ADDR && rw;

   // Bit engine; SDA only changes on SCL low
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_shift = shift;
      next_tx = tx;
      next_drive = drive;
      next_rw = rw;
      next_cmd = cmd;
      next_extra = extra;
      if (start_c) begin
         next_state = ST_ADDR;
         next_cnt = 4'h0;
         next_drive = 1'b0;
         next_extra = 1'b0;
      end else if (stop_c) begin
         next_state = ST_IDLE;
         next_drive = 1'b0;
      end else if (rise) begin
         if (state == ST_ADDR || state == ST_CMD || state == ST_WDATA) begin
            next_shift = {shift[6:0], sda_in};
            next_cnt = cnt + 4'h1;
         end else if (state == ST_ACK_R && sda_in) begin
            next_state = ST_IDLE; // Controller NACK ends the read
         end
      end else if (fall) begin
         case (state)
            ST_ADDR: begin
               if (cnt == 4'h8) begin
                  next_state = (shift[7:1] == DEV_ADDR) ? ST_ACK_ADDR : ST_IDLE;
                  next_drive = (shift[7:1] == DEV_ADDR);
                  next_rw = shift[0];
               end
            end
            ST_ACK_ADDR: begin
               // RQ10 snapshot whole byte
               if (rw) begin
                  next_tx = rd_data;
                  next_drive = !rd_data[7];
                  next_cnt = 4'h1;
                  next_state = ST_RDATA;
               end else begin
                  next_drive = 1'b0;
                  next_cnt = 4'h0;
                  next_state = ST_CMD;
               end
            end
            ST_CMD: begin
               if (cnt == 4'h8) begin
                  next_cmd = shift;
                  next_drive = 1'b1;
                  next_state = ST_ACK_CMD;
               end
            end
            ST_WDATA: begin
               if (cnt == 4'h8) begin
                  next_drive = 1'b1;
                  next_state = ST_ACK_W;
               end
            end
            ST_ACK_CMD, ST_ACK_W: begin
               // RQ1 write data dropped
               next_drive = 1'b0;
               next_cnt = 4'h0;
               next_state = ST_WDATA;
            end
            ST_RDATA: begin
               if (cnt == 4'h8) begin
                  next_drive = 1'b0;
                  next_state = ST_ACK_R;
               end else begin
                  next_drive = !tx[6];
                  next_tx = {tx[6:0], 1'b1};
                  next_cnt = cnt + 4'h1;
               end
            end
            ST_ACK_R: begin
               // RQ3 only one real byte
               next_tx = pse_class_pkg::SPENT_BYTE;
               next_drive = 1'b0;
               next_cnt = 4'h1;
               next_extra = 1'b1;
               next_state = ST_RDATA;
            end
            default: next_state = ST_IDLE;
         endcase
      end
   end

   // Registers of the bit engine
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         cnt <= 4'h0;
         shift <= 8'h00;
         tx <= 8'h00;
         drive <= 1'b0;
         rw <= 1'b0;
         cmd <= 8'h00;
         extra <= 1'b0;
      end else begin
         state <= next_state;
         scl_q <= scl_in;
         sda_q <= sda_in;
         cnt <= next_cnt;
         shift <= next_shift;
         tx <= next_tx;
         drive <= next_drive;
         rw <= next_rw;
         cmd <= next_cmd;
         extra <= next_extra;
      end
   end

   a_read_snapshot: assert property (@(posedge clk) disable iff (!rst_n) // RQ10
      rd_req |=> tx == $past(rd_data) && drive == !$past(rd_data[7]))
      else $error("read byte not captured whole");

   a_single_byte: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
      extra && state == ST_RDATA |-> !drive)
      else $error("target drove a second data byte");

endmodule : i2c_byte_target

// [design/pse_class_cap_readback.sv]
// Read-only class and capacitance result bank behind the serial port
// Behaviour
// RQ1: The fourth channel's capacitance byte reads at command 4Bh and writes change nothing.
// RQ2: The capacitance byte loads the latest 8-bit result and is zero after reset.
// RQ3: Each access moves exactly one data byte; further bytes are released lines.
// RQ4: Four class bytes for channels one to four read at 4Ch to 4Fh, zero after reset.
// RQ5: Turning a channel off clears both class nibbles of that channel.
// RQ6: The granted class sits in bits 7 to 4 using the legal codes, others read unknown.
// RQ7: The prior class sits in bits 3 to 0, kept apart from the granted class.
// RQ8: A device that showed class 0 is recorded with granted class 3.
// RQ9: The prior class is kept only in semi-auto mode with detection and class enabled.
// RQ10: Each byte updates in one clock and a read captures it whole.
`timescale 1ns/1ns
module pse_class_cap_readback #(
   parameter int NUM_CH = 4,
   parameter logic [6:0] DEV_ADDR = 7'h20
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic cap_done,
   input wire logic [7:0] cap_result_bits,
   input pse_class_pkg::class_report_t report [NUM_CH],
   input pse_class_pkg::chan_state_t chan [NUM_CH],
   output logic [7:0] cap_byte,
   output logic [7:0] class_byte [NUM_CH]
);

   // -------------------------------------------------------------
   // Elaboration checks
   // -------------------------------------------------------------
   // Command codes are fixed, so the channel count cannot grow
   if (NUM_CH != 4) begin : g_bad_ch
      $error("NUM_CH must be 4");
   end

   // Legal granted class code
   function automatic logic granted_legal(input logic [3:0] code);
      granted_legal = (code <= pse_class_pkg::CLS_4)
         || (code >= pse_class_pkg::CLS_5_SS && code <= pse_class_pkg::CLS_8_SS)
         || (code == pse_class_pkg::CLS_5_DS);
   endfunction : granted_legal

   // Map a reported class to the code stored as granted class
   function automatic logic [3:0] granted_code(input logic [3:0] code);
      if (code == pse_class_pkg::CLS_0) begin
         granted_code = pse_class_pkg::CLS_3;
      end else if (granted_legal(code)) begin
         granted_code = code;
      end else begin
         granted_code = pse_class_pkg::CLS_UNKNOWN;
      end
   endfunction : granted_code

   logic [7:0] cmd, rd_data, next_cap;
   logic rd_req;

   // -------------------------------------------------------------
   // Capacitance result
   // -------------------------------------------------------------
   // RQ2 load latest result
   always_comb begin
      next_cap = cap_byte;
      if (cap_done) begin
         next_cap = cap_result_bits;
      end
   end

   // Whole byte moves in one edge, never bit by bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_byte <= pse_class_pkg::CAP_RESET;
      end else begin
         cap_byte <= next_cap;
      end
   end

   a_cap_load: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
      cap_done |=> cap_byte == $past(cap_result_bits))
      else $error("capacitance byte missed its result");

   a_cap_readonly: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
      !cap_done |=> $stable(cap_byte))
      else $error("capacitance byte changed without a result");

   a_reset_zero: assert property (@(posedge clk) // RQ4
      $rose(rst_n) |-> cap_byte == pse_class_pkg::CAP_RESET
         && class_byte[0] == pse_class_pkg::CLASS_RESET
         && class_byte[3] == pse_class_pkg::CLASS_RESET)
      else $error("result bytes not zero after reset");

   // -------------------------------------------------------------
   // Class bytes, one per channel
   // -------------------------------------------------------------
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic [7:0] next_class;
      logic prior_ok;

      // RQ9 prior class gate
      assign prior_ok = chan[ch].semi_auto && chan[ch].detect_en && chan[ch].class_en;

      // Turn-off wins over a report in the same cycle: the channel is dead
      always_comb begin
         next_class = class_byte[ch];
         if (chan[ch].off) begin
            // RQ5 clear on turn-off
            next_class = pse_class_pkg::CLASS_RESET;
         end else if (report[ch].valid) begin
            // RQ6 RQ8 granted nibble
            next_class[pse_class_pkg::GRANTED_MSB:pse_class_pkg::GRANTED_LSB] =
               granted_code(report[ch].granted);
            // RQ7 prior nibble
            next_class[pse_class_pkg::PRIOR_MSB:pse_class_pkg::PRIOR_LSB] =
               prior_ok ? report[ch].prior : pse_class_pkg::CLS_UNKNOWN;
         end
      end

      // Both nibbles written on one edge
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            class_byte[ch] <= pse_class_pkg::CLASS_RESET;
         end else begin
            class_byte[ch] <= next_class;
         end
      end

      // Checks per channel; each watches the registered byte
      a_off_clears: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
         chan[ch].off |=> class_byte[ch] == pse_class_pkg::CLASS_RESET)
         else $error("class byte kept after turn-off");

      a_granted_legal: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
         report[ch].valid && !chan[ch].off |=> granted_legal(class_byte[ch][7:4]))
         else $error("granted class holds a reserved code");

      a_class0_map: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
         report[ch].valid && !chan[ch].off && report[ch].granted == pse_class_pkg::CLS_0
         |=> class_byte[ch][7:4] == pse_class_pkg::CLS_3)
         else $error("class 0 not recorded as class 3");

      a_prior_field: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
         report[ch].valid && !chan[ch].off && prior_ok
         |=> class_byte[ch][3:0] == $past(report[ch].prior))
         else $error("prior class nibble wrong");

      a_prior_gate: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
         report[ch].valid && !chan[ch].off && !prior_ok
         |=> class_byte[ch][3:0] == pse_class_pkg::CLS_UNKNOWN)
         else $error("prior class kept outside semi-auto discovery");

      a_granted_copy: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
         report[ch].valid && !chan[ch].off && granted_legal(report[ch].granted)
         |=> class_byte[ch][7:4] == $past(report[ch].granted))
         else $error("legal granted class not stored as reported");

      a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
         report[ch].valid && !chan[ch].off && !granted_legal(report[ch].granted)
         && report[ch].granted != pse_class_pkg::CLS_0
         |=> class_byte[ch][7:4] == pse_class_pkg::CLS_UNKNOWN)
         else $error("reserved granted class not stored as unknown");

      a_class_hold: assert property (@(posedge clk) disable iff (!rst_n) // RQ10
         !report[ch].valid && !chan[ch].off |=> $stable(class_byte[ch]))
         else $error("class byte changed without a report");

      // No disable here: the check looks at the release edge itself
      a_class_reset: assert property (@(posedge clk) // RQ4
         $rose(rst_n) |-> class_byte[ch] == pse_class_pkg::CLASS_RESET)
         else $error("class byte not zero after reset");

      // Snapshot reaches the pin one clock after the acknowledge fall
      a_map_class: assert property (@(posedge clk) disable iff (!rst_n) // RQ4
         rd_req && cmd == 8'(pse_class_pkg::OFF_CH1_CLASS + ch)
         |=> sda_oe_n == $past(class_byte[ch][7]))
         else $error("first bit of class read wrong");
   end

   // -------------------------------------------------------------
   // Read decode
   // -------------------------------------------------------------
   // RQ1 RQ4 command map
   always_comb begin
      case (cmd)
         pse_class_pkg::OFF_CH4_CAP: rd_data = cap_byte;
         pse_class_pkg::OFF_CH1_CLASS: rd_data = class_byte[0];
         pse_class_pkg::OFF_CH2_CLASS: rd_data = class_byte[1];
         pse_class_pkg::OFF_CH3_CLASS: rd_data = class_byte[2];
         pse_class_pkg::OFF_CH4_CLASS: rd_data = class_byte[3];
         default: rd_data = pse_class_pkg::UNMAPPED_READ;
      endcase
   end

   a_map_ch4_cap: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
      rd_req && cmd == pse_class_pkg::OFF_CH4_CAP && !cap_done
      |=> sda_oe_n == $past(cap_byte[7]))
      else $error("first bit of capacitance read wrong");

   // Stray pointers read zero rather than a neighbour's byte
   a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_n) // RQ4
      rd_req && (cmd < pse_class_pkg::OFF_CH4_CAP || cmd > pse_class_pkg::OFF_CH4_CLASS)
      |=> !sda_oe_n)
      else $error("unmapped command did not read zero");

   // Serial port; writes are acknowledged but never stored
   i2c_byte_target #(
      .DEV_ADDR(DEV_ADDR)
   ) u_port (
      .clk(clk),
      .rst_n(rst_n),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe_n(sda_oe_n),
      .cmd(cmd),
      .rd_req(rd_req),
      .rd_data(rd_data)
   );

endmodule : pse_class_cap_readback

// [bench/i2c_host_model.sv]
// Serial bus controller model: command writes and byte reads
`timescale 1ns/1ns
module i2c_host_model #(
   parameter logic [6:0] ADDR = 7'h20
) (
   input wire logic clk,
   input wire logic sda_in,
   output logic scl,
   output logic sda_oe_n
);
   // ------------------------------
   // Bus phases
   // ------------------------------
   initial begin
      scl = 1'b1;
      sda_oe_n = 1'b1;
   end
   // Quarter bit of eight clocks keeps line edges far apart
   task automatic q();
      repeat (8) @(negedge clk);
   endtask : q
   // Start from idle or repeated start; clock stands high between frames
   task automatic start();
      sda_oe_n = 1'b1;
      q();
      scl = 1'b1;
      q();
      sda_oe_n = 1'b0;
      q();
      scl = 1'b0;
   endtask : start
   task automatic stop();
      sda_oe_n = 1'b0;
      q();
      scl = 1'b1;
      q();
      sda_oe_n = 1'b1;
      q();
   endtask : stop
   // One bit: drive b (1 releases), sample line while clock is high
   task automatic bit_x(input logic b, output logic r);
      sda_oe_n = b;
      q();
      scl = 1'b1;
      q();
      r = sda_in;
      q();
      scl = 1'b0;
      q();
   endtask : bit_x
   task automatic byte_x(input logic [7:0] d, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
   endtask : byte_x
   task automatic wr(input logic [7:0] cmd, input logic [7:0] data, input logic send);
      logic [7:0] j;
      logic a;
      start();
      byte_x({ADDR, 1'b0}, j);
      bit_x(1'b1, a);
      byte_x(cmd, j);
      bit_x(1'b1, a);
      if (send) begin
         byte_x(data, j);
         bit_x(1'b1, a);
      end
      stop();
   endtask : wr
   // pointer write, then one byte; more asks a second byte
   task automatic rd(input logic [7:0] cmd, input logic more, output logic [7:0] d0,
                     output logic [7:0] d1);
      logic a;
      wr(cmd, 8'h00, 1'b0);
      start();
      byte_x({ADDR, 1'b1}, d0);
      bit_x(1'b1, a);
      byte_x(8'hff, d0);
      bit_x(!more, a);
      d1 = 8'h00;
      if (more) begin
         byte_x(8'hff, d1);
         bit_x(1'b1, a);
      end
      stop();
   endtask : rd
endmodule : i2c_host_model

// [bench/tb.sv]
// Self-checking bench of the class and capacitance readback bank
`timescale 1ns/1ns
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cap_done = 1'b0;
   logic [7:0] cap_result_bits = 8'h00;
   pse_class_pkg::class_report_t report [4];
   pse_class_pkg::chan_state_t chan [4];
   logic [7:0] cap_byte;
   logic [7:0] class_byte [4];
   logic scl, h_oe_n, d_oe_n, d_out, sda;
   logic [7:0] seed = 8'h5a;
   logic [7:0] r0, r1;
   int n_mismatch = 0;
   int total_checks = 0;
   int m_cap;
   int m_cls [4];
   always #2 clk = ~clk;
   // Pull-up: line low while either side enables its driver
   assign sda = (d_oe_n | d_out) & h_oe_n;
   pse_class_cap_readback u_dut (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
      .sda_out(d_out), .sda_oe_n(d_oe_n), .cap_done(cap_done),
      .cap_result_bits(cap_result_bits), .report(report), .chan(chan),
      .cap_byte(cap_byte), .class_byte(class_byte));
   i2c_host_model u_host (.clk(clk), .sda_in(sda), .scl(scl), .sda_oe_n(h_oe_n));
   // ------------------------------
   // Model and checks
   // ------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   // Class 0 stored as class 3; reserved codes read as unknown
   function automatic int grant(input int g);
      if (g == 6) return 3;
      if (g == 5 || g == 7 || g == 12 || g == 14 || g == 15) return 0;
      return g;
   endfunction : grant
   task automatic chk(input string nm, input int e, input logic [7:0] g);
      total_checks++;
      if (g !== e[7:0]) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e[7:0], g);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   task automatic cmp_all();
      chk("cap_byte", m_cap, cap_byte);
      for (int c = 0; c < 4; c++) chk("class_byte", m_cls[c], class_byte[c]);
   endtask : cmp_all
   // Random loads on all inputs in one cycle; model follows the same edge
   task automatic drive(input int g);
      seed = lfsr(seed);
      cap_done = seed[0];
      seed = lfsr(seed);
      cap_result_bits = seed;
      if (cap_done) m_cap = cap_result_bits;
      for (int c = 0; c < 4; c++) begin
         seed = lfsr(seed);
         report[c] = '{seed[7] | seed[6], 4'(g + c), seed[3:0]};
         seed = lfsr(seed);
         chan[c] = '{seed[6:4] == 3'h0, seed[1] | seed[0], seed[2] | seed[0], seed[3] | seed[0]};
         if (chan[c].off) m_cls[c] = 0;
         else if (report[c].valid) m_cls[c] = grant(report[c].granted) * 16 +
            ((chan[c].semi_auto && chan[c].detect_en && chan[c].class_en) ? report[c].prior : 0);
      end
   endtask : drive
   task automatic quiet();
      cap_done = 1'b0;
      for (int c = 0; c < 4; c++) begin
         report[c].valid = 1'b0;
         chan[c].off = 1'b0;
      end
   endtask : quiet
   task automatic rd_all();
      u_host.rd(pse_class_pkg::OFF_CH4_CAP, 1'b0, r0, r1);
      chk("rd_cap", m_cap, r0);
      for (int c = 0; c < 4; c++) begin
         u_host.rd(pse_class_pkg::OFF_CH1_CLASS + 8'(c), 1'b0, r0, r1);
         chk("rd_class", m_cls[c], r0);
      end
   endtask : rd_all
   // ------------------------------
   // Sequence
   // ------------------------------
   initial begin
      repeat (90000) @(posedge clk);
      n_mismatch++;
      $display("timeout reached");
      tally_and_finish();
   end
   initial begin
      m_cap = 0;
      for (int c = 0; c < 4; c++) begin
         report[c] = '0;
         chan[c] = '0;
         m_cls[c] = 0;
      end
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      cmp_all();
      chk("sda_out", 0, {7'h00, d_out});
      rd_all();
      u_host.rd(8'h50, 1'b0, r0, r1);
      chk("unmapped", pse_class_pkg::UNMAPPED_READ, r0);
      $display("test reset_values done");
      // Every granted code on every channel, loads back to back
      for (int g = 0; g < 48; g++) begin
         @(negedge clk);
         cmp_all();
         drive(g);
      end
      @(negedge clk);
      cmp_all();
      quiet();
      $display("test class_codes done");
      rd_all();
      // A write to the read-only byte changes nothing
      u_host.wr(pse_class_pkg::OFF_CH4_CAP, ~m_cap[7:0], 1'b1);
      rd_all();
      u_host.rd(pse_class_pkg::OFF_CH1_CLASS, 1'b1, r0, r1);
      chk("burst_first", m_cls[0], r0);
      chk("burst_extra", pse_class_pkg::SPENT_BYTE, r1);
      // A foreign address gets no acknowledge, the default address gets one
      u_host.start();
      u_host.byte_x(8'hbf, r0);
      u_host.bit_x(1'b1, r1[0]);
      u_host.start();
      u_host.byte_x(8'h40, r0);
      u_host.bit_x(1'b1, r1[1]);
      u_host.stop();
      chk("foreign_ack", 1, {7'h00, r1[0]});
      chk("own_ack", 0, {7'h00, r1[1]});
      $display("test bus_access done");
      // New result lands while the byte is on the wire: old byte whole
      fork
         u_host.rd(pse_class_pkg::OFF_CH4_CAP, 1'b0, r0, r1);
         begin
            repeat (1040) @(negedge clk);
            cap_done = 1'b1;
            cap_result_bits = ~m_cap[7:0];
            @(negedge clk);
            cap_done = 1'b0;
         end
      join
      chk("rd_during_load", m_cap, r0);
      m_cap = m_cap ^ 255;
      cmp_all();
      $display("test atomic_load done");
      @(negedge clk);
      rst_n = 1'b0;
      m_cap = 0;
      for (int c = 0; c < 4; c++) m_cls[c] = 0;
      @(negedge clk);
      cmp_all();
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      rd_all();
      $display("test mid_reset done");
      tally_and_finish();
   end
endmodule : tb
